//--- qclk_top.sv
// Quadrature clocking, fetch pipeline and reset state control
// Functional notes
// (RULE1) External clock mode drives out a clock of four input periods.
// (RULE2) RC mode drives out oscillator divided by four.
// (RULE3) Input clock divides by four into four one-hot phases in order.
// (RULE4) Program counter increments once per cycle in phase one.
// (RULE5) Word at program counter is captured by phase four.
// (RULE6) Fetched word loads the instruction latch at phase one, executes after.
// (RULE7) Fetch overlaps execute; one instruction per four-phase cycle.
// (RULE8) Branches take two cycles; the prefetched word is discarded.
// (RULE9) Operand read in phase two, result write in phase four.
// (RULE10) Four reset sources: power-on, brown-out, master clear, watchdog.
// (RULE11) Some registers survive every reset; most take reset values.
// (RULE12) Timeout and powerdown flags with POR and BOR give reset cause.
// (RULE13) Reset forces all port direction bits to one.
// (RULE14) Peripherals may reassign pins on reset.
// (RULE15) Phase generator held in phase one during reset.
// (RULE16) In external execution modes reset drives latch low, strobes high.
// (RULE17) Power-on reset holds device until supply is good, both edges.
// (RULE18) Two-bit select picks one of four oscillator modes.
// (RULE19) Power-up timer holds reset 96 ms after power-on or brown-out.
// (RULE20) Start-up timer counts 1024 cycles with power-up or crystal wake.
// (RULE21) Phases restart at phase one after reset; clock out stays aligned.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
module qclk_top
  import qclk_pkg::*;
#(
  parameter int POWER_UP_TIMER_COUNT = POWER_UP_TIMER_CYCLES,
  parameter int OST_COUNT = OST_CYCLES
)(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Reset sources
  input wire logic supply_good_i,
  input wire logic brown_out_i,
  input wire logic master_clear_n_i,
  input wire logic watchdog_timeout_i,
  input wire logic [1:0] osc_mode_select_i,
  // Program memory
  output logic [15:0] prog_addr_o,
  input wire logic [15:0] prog_data_i,
  // Phases and pins
  output logic [3:0] phase_o,
  output logic osc_out_pin_o,
  output logic osc_out_en_o,
  output logic address_latch_pin_o,
  output logic output_enable_pin_o,
  output logic write_strobe_pin_o,
  output logic ext_bus_en_o,
  output logic [7:0] port_dir_o,
  output logic pins_to_peripheral_o,
  output logic data_read_o,
  output logic data_write_o,
  output logic in_reset_o,
  // AXI4-Lite
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Reset release and pin synchronisers
  logic [1:0] rst_sync;
  logic rst_n;
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1 <= 5'h0;
      pin_s2 <= 5'h0;
    end else begin
      pin_s1 <= {supply_good_i, brown_out_i, master_clear_n_i, watchdog_timeout_i, 1'b0};
      pin_s2 <= pin_s1;
    end
  end

  logic supply_ok;
  logic bor_evt;
  logic master_clear_input_n;
  logic wdt_evt;
  assign supply_ok = pin_s2[4];
  assign bor_evt = pin_s2[3];
  assign master_clear_input_n = pin_s2[2];
  assign wdt_evt = pin_s2[1];

  // ==========================================================
  // Strap capture after release
  osc_mode_t osc_mode;
  logic mode_taken;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      osc_mode <= external_clock_mode;
      mode_taken <= 1'b0;
    end else if (!mode_taken) begin
      osc_mode <= osc_mode_t'(osc_mode_select_i); // (RULE18)
      mode_taken <= 1'b1;
    end
  end

  // ==========================================================
  // Reset sequencer
  typedef enum logic [1:0] {st_hold, st_timers, st_run} rst_state_t;
  rst_state_t state;
  logic [31:0] power_up_timer_cnt;
  logic [31:0] ost_cnt;
  logic supply_prev;
  logic sleeping;
  logic [31:0] ctrl;
  logic core_rst;
  logic por_flag;
  logic bor_flag;
  logic to_flag;
  logic pd_flag;
  logic crystal;
  // Only power-on and brown-out start the long power-up wait
  logic power_evt;

  assign crystal = (osc_mode == standard_crystal_mode) ||
                   (osc_mode == low_frequency_crystal_mode);
  assign core_rst = (state != st_run);

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_hold;
      power_up_timer_cnt <= 32'h0;
      ost_cnt <= 32'h0;
      supply_prev <= 1'b0;
      por_flag <= 1'b0;
      bor_flag <= 1'b0;
      to_flag <= 1'b1;
      pd_flag <= 1'b1;
      power_evt <= 1'b1;
    end else begin
      supply_prev <= supply_ok;
      case (state)
        st_hold: begin
          // Held on any supply crossing until the supply is good and master clear is released
          if (supply_ok && master_clear_input_n) begin // (RULE17)
            state <= st_timers;
            power_up_timer_cnt <= power_evt ? POWER_UP_TIMER_COUNT : 32'h0; // (RULE19)
            ost_cnt <= (power_evt || (crystal && sleeping)) ? OST_COUNT : 32'h0; // (RULE20)
          end
        end
        st_timers: begin
          if (power_up_timer_cnt != 32'h0) begin
            power_up_timer_cnt <= power_up_timer_cnt - 32'h1;
          end
          if (ost_cnt != 32'h0) begin
            ost_cnt <= ost_cnt - 32'h1;
          end
          if (power_up_timer_cnt == 32'h0 && ost_cnt == 32'h0) begin
            state <= st_run;
          end
        end
        st_run: begin
          // Power-on, brown-out, master clear, watchdog
          if (!supply_ok || supply_ok != supply_prev) begin // (RULE10)
            state <= st_hold;
            por_flag <= 1'b0; // (RULE12)
            to_flag <= 1'b1;
            pd_flag <= 1'b1;
            power_evt <= 1'b1;
          end else if (bor_evt) begin
            state <= st_hold;
            bor_flag <= 1'b0;
            to_flag <= 1'b1;
            pd_flag <= 1'b1;
            power_evt <= 1'b1;
          end else if (!master_clear_input_n) begin
            state <= st_hold;
            to_flag <= 1'b1;
            pd_flag <= ~sleeping;
            power_evt <= 1'b0;
          end else if (wdt_evt) begin
            state <= st_hold;
            to_flag <= 1'b0;
            pd_flag <= ~sleeping;
            power_evt <= 1'b0;
          end else if (s_axi_wvalid && s_axi_awvalid && s_axi_awaddr == STATUS_ADDR
                       && s_axi_awready) begin
            // Software rearms the POR and BOR cause flags
            por_flag <= por_flag | s_axi_wdata[ST_POR_BIT];
            bor_flag <= bor_flag | s_axi_wdata[ST_BOR_BIT];
          end
        end
        default: state <= st_hold;
      endcase
    end
  end

  // ==========================================================
  // Phase generator
  logic [3:0] ph;
  logic clkout;

  phase_gen u_phase (
    .clk_i(clk_i),
    .nrst_i(rst_n),
    .hold_i(core_rst), // (RULE15)
    .phase_o(ph),
    .clkout_o(clkout)
  );

  // ==========================================================
  // Fetch and execute pipeline
  logic [15:0] pc;
  logic [15:0] fetched;
  logic [15:0] ir;
  logic flush;
  logic [15:0] branch_target;
  logic [7:0] port_dir;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pc <= PC_RESET;
      fetched <= 16'h0000;
      ir <= 16'h0000;
      flush <= 1'b0;
    end else if (core_rst) begin
      pc <= PC_RESET;
      flush <= 1'b0;
      // Latch contents survive reset
    end else begin // (RULE11)
      if (ph[0]) begin
        pc <= pc + 16'h0001; // (RULE4)
        ir <= flush ? 16'h0000 : fetched; // (RULE6) (RULE8)
        flush <= 1'b0;
      end
      if (ph[3]) begin
        fetched <= prog_data_i; // (RULE5) (RULE7)
        if (ctrl[CTRL_BRANCH_BIT] && ir != 16'h0000) begin
          pc <= branch_target; // (RULE8)
          flush <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Pins and core outputs
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase_o <= 4'h1;
      osc_out_pin_o <= 1'b0;
      osc_out_en_o <= 1'b0;
      address_latch_pin_o <= 1'b0;
      output_enable_pin_o <= 1'b1;
      write_strobe_pin_o <= 1'b1;
      ext_bus_en_o <= 1'b0;
      port_dir_o <= DDR_RESET;
      pins_to_peripheral_o <= 1'b1;
      data_read_o <= 1'b0;
      data_write_o <= 1'b0;
      in_reset_o <= 1'b1;
      prog_addr_o <= PC_RESET;
    end else begin
      phase_o <= ph;
      osc_out_pin_o <= clkout; // (RULE1) (RULE2)
      osc_out_en_o <= (osc_mode == external_clock_mode) ||
                      (osc_mode == resistor_capacitor_mode);
      ext_bus_en_o <= ctrl[CTRL_EXTEXEC_BIT];
      in_reset_o <= core_rst;
      prog_addr_o <= pc;
      pins_to_peripheral_o <= core_rst ? 1'b1 : 1'b0; // (RULE14)
      if (core_rst) begin
        port_dir_o <= DDR_RESET; // (RULE13)
        address_latch_pin_o <= 1'b0; // (RULE16)
        output_enable_pin_o <= 1'b1;
        write_strobe_pin_o <= 1'b1;
        data_read_o <= 1'b0;
        data_write_o <= 1'b0;
      end else begin
        port_dir_o <= port_dir;
        address_latch_pin_o <= ph[0];
        output_enable_pin_o <= ~ph[2];
        write_strobe_pin_o <= ~ph[3];
        data_read_o <= ph[1]; // (RULE9)
        data_write_o <= ph[3]; // (RULE9)
      end
    end
  end

  // ==========================================================
  // AXI4-Lite slave, one write and one read at a time
  logic aw_ok;
  logic [31:0] scratch;
  assign aw_ok = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign sleeping = ctrl[CTRL_SLEEP_BIT];
  assign branch_target = ctrl[31:16];

  // No reset at all: contents survive every reset kind
  always_ff @(posedge clk_i) begin
    if (aw_ok && !s_axi_awready && s_axi_awaddr == SCRATCH_ADDR) begin
      scratch <= s_axi_wdata; // (RULE11)
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= AXI_OKAY;
      ctrl <= 32'h0;
      port_dir <= DDR_RESET;
    end else begin
      s_axi_awready <= aw_ok && !s_axi_awready;
      s_axi_wready <= aw_ok && !s_axi_awready;
      if (core_rst) begin
        port_dir <= DDR_RESET; // (RULE13)
      end
      if (aw_ok && !s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= AXI_OKAY;
        case (s_axi_awaddr)
          CTRL_ADDR: ctrl <= s_axi_wdata;
          DDR_ADDR: if (!core_rst && s_axi_wstrb[0]) port_dir <= s_axi_wdata[7:0];
          STATUS_ADDR: s_axi_bresp <= AXI_OKAY;
          SCRATCH_ADDR: s_axi_bresp <= AXI_OKAY;
          default: s_axi_bresp <= AXI_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= AXI_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= AXI_OKAY;
        case (s_axi_araddr)
          CTRL_ADDR: s_axi_rdata <= ctrl;
          STATUS_ADDR: s_axi_rdata <= {22'h0, osc_mode, 3'h0, core_rst,
                                       to_flag, pd_flag, bor_flag, por_flag}; // (RULE12)
          PC_ADDR: s_axi_rdata <= {16'h0, pc};
          IR_ADDR: s_axi_rdata <= {16'h0, ir};
          DDR_ADDR: s_axi_rdata <= {24'h0, port_dir};
          SCRATCH_ADDR: s_axi_rdata <= scratch; // (RULE11)
          FETCH_ADDR: s_axi_rdata <= {16'h0, fetched};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= AXI_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- qclk_pkg.sv
// Shared constants for the quadrature clock and reset state block
package qclk_pkg;

  // ==========================================================
  // Oscillator modes
  typedef enum logic [1:0] {
    low_frequency_crystal_mode = 2'h0,
    standard_crystal_mode = 2'h1,
    external_clock_mode = 2'h2,
    resistor_capacitor_mode = 2'h3
  } osc_mode_t;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 10000000;
  localparam int POWER_UP_TIMER_MS = 96;
  localparam int POWER_UP_TIMER_CYCLES = (POWER_UP_TIMER_MS * (CLK_HZ / 1000));
  localparam int OST_CYCLES = 1024;
  localparam int PHASES = 4;

  // ==========================================================
  // AXI4-Lite register map
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] PC_ADDR = 8'h08;
  localparam logic [7:0] IR_ADDR = 8'h0C;
  localparam logic [7:0] DDR_ADDR = 8'h10;
  localparam logic [7:0] SCRATCH_ADDR = 8'h14;
  localparam logic [7:0] FETCH_ADDR = 8'h18;

  // CTRL bits
  localparam int CTRL_BRANCH_BIT = 0;
  localparam int CTRL_EXTEXEC_BIT = 1;
  localparam int CTRL_SLEEP_BIT = 2;
  // STATUS bits
  localparam int ST_POR_BIT = 0;
  localparam int ST_BOR_BIT = 1;
  localparam int ST_PD_BIT = 2;
  localparam int ST_TO_BIT = 3;
  localparam int ST_RESET_BIT = 4;
  localparam int ST_MODE_LSB = 8;

  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [7:0] DDR_RESET = 8'hFF;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage

//--- phase_gen.sv
// Divide-by-four quadrature phase generator
module phase_gen
  import qclk_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Control
  input wire logic hold_i,
  // Phases
  output logic [3:0] phase_o,
  output logic clkout_o
);

  // ==========================================================
  // Phase ring
  logic [1:0] count;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= 2'h0;
    end else if (hold_i) begin
      count <= 2'h0; // (RULE15)
    end else begin
      count <= count + 2'h1; // (RULE3)
    end
  end

  // One-hot, so phases never overlap
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_o <= 4'h1;
      clkout_o <= 1'b1;
    end else begin
      phase_o <= 4'h1 << ((hold_i) ? 2'h0 : count + 2'h1); // (RULE3)
      // High in phase one and two, low in three and four
      clkout_o <= hold_i | (count == 2'h3) | (count == 2'h0); // (RULE21)
    end
  end

endmodule

//--- prog_mem_model.sv
// Program memory model on the fetch side of the block
module prog_mem_model (
  // Fetch
  input wire logic [15:0] addr_i,
  input wire logic [15:0] word_i,
  output logic [15:0] data_o
);
  // ==========
  // Read path
  // Whole program is one word; upper half of the space reads inverted
  assign data_o = addr_i[15] ? ~word_i : word_i;
endmodule

//--- qclk_top_chk.sv
// Port checker for the quadrature clock block
module qclk_top_chk
  import qclk_pkg::*;
#(
  parameter int POWER_UP_TIMER_COUNT = POWER_UP_TIMER_CYCLES,
  parameter int OST_COUNT = OST_CYCLES
)(
  // Watched ports
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic [1:0] osc_mode_select_i,
  input wire logic [15:0] prog_addr_o,
  input wire logic [3:0] phase_o,
  input wire logic osc_out_pin_o,
  input wire logic osc_out_en_o,
  input wire logic address_latch_pin_o,
  input wire logic output_enable_pin_o,
  input wire logic write_strobe_pin_o,
  input wire logic [7:0] port_dir_o,
  input wire logic pins_to_peripheral_o,
  input wire logic data_read_o,
  input wire logic data_write_o,
  input wire logic in_reset_o,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready
);
  // ==========
  // Sequences
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  sequence clk_rise_s;
    $rose(osc_out_pin_o) && osc_out_en_o;
  endsequence
  sequence run5_s;
    (!in_reset_o) [*5];
  endsequence
  sequence restart_s;
    phase_o == 4'h1 ##1 phase_o == 4'h2;
  endsequence
  // ==========
  // Assertions
  phase_hot_a: assert property (!in_reset_o |-> $onehot(phase_o))
    else $error("phase not one-hot");
  phase_order_a: assert property (!in_reset_o && !$past(in_reset_o, 2) && !$past(in_reset_o)
    |-> phase_o == {$past(phase_o[2:0]), $past(phase_o[3])}) else $error("phase out of order");
  clkout_period_a: assert property (clk_rise_s ##0 run5_s |-> $rose(osc_out_pin_o))
    else $error("clock out period not four");
  clkout_align_a: assert property ($rose(osc_out_pin_o) && !in_reset_o |-> phase_o == 4'h1)
    else $error("clock out not aligned to phase one");
  clkout_en_a: assert property (!in_reset_o |-> osc_out_en_o == osc_mode_select_i[1])
    else $error("clock out enable wrong for mode");
  reset_phase_a: assert property (in_reset_o && $past(in_reset_o) |-> phase_o == 4'h1)
    else $error("phase moves in reset");
  reset_dir_a: assert property (in_reset_o && $past(in_reset_o) |-> port_dir_o == 8'hFF)
    else $error("direction not forced in reset");
  reset_pins_a: assert property (in_reset_o && $past(in_reset_o) |->
    !address_latch_pin_o && output_enable_pin_o && write_strobe_pin_o) else $error("bus pins");
  reset_periph_a: assert property (in_reset_o && $past(in_reset_o) |-> pins_to_peripheral_o)
    else $error("pins not handed to peripherals");
  release_phase_a: assert property ($fell(in_reset_o) |-> ##[0:1] restart_s)
    else $error("no restart at phase one");
  read_slot_a: assert property (data_read_o |-> phase_o == 4'h2)
    else $error("operand read outside phase two");
  write_slot_a: assert property (data_write_o |-> phase_o == 4'h8)
    else $error("result write outside phase four");
  pc_step_a: assert property (!in_reset_o && $changed(prog_addr_o)
    |-> phase_o == 4'h1 || $past(phase_o) == 4'h1) else $error("counter moved off phase one");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
endmodule

bind qclk_top qclk_top_chk #(.POWER_UP_TIMER_COUNT(POWER_UP_TIMER_COUNT), .OST_COUNT(OST_COUNT)) chk_i (
  .clk_i(clk_i), .nrst_i(nrst_i), .osc_mode_select_i(osc_mode_select_i),
  .prog_addr_o(prog_addr_o), .phase_o(phase_o), .osc_out_pin_o(osc_out_pin_o),
  .osc_out_en_o(osc_out_en_o), .address_latch_pin_o(address_latch_pin_o),
  .output_enable_pin_o(output_enable_pin_o), .write_strobe_pin_o(write_strobe_pin_o),
  .port_dir_o(port_dir_o), .pins_to_peripheral_o(pins_to_peripheral_o),
  .data_read_o(data_read_o), .data_write_o(data_write_o), .in_reset_o(in_reset_o),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready));

//--- tb_qclk_top.sv
// Self-checking bench for the quadrature clock block
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, e); end end
module tb_qclk_top;
  timeunit 1ns;
  timeprecision 1ns;
  import qclk_pkg::*;
  // ==========
  // Signals
  logic clk_i, nrst_i, supply_good_i, brown_out_i, master_clear_n_i, watchdog_timeout_i;
  logic [1:0] osc_mode_select_i, s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] prog_addr_o, prog_data_i, word, tgt, a;
  logic [3:0] phase_o, s_axi_wstrb;
  logic osc_out_pin_o, osc_out_en_o, address_latch_pin_o, output_enable_pin_o;
  logic write_strobe_pin_o, ext_bus_en_o, pins_to_peripheral_o, data_read_o, data_write_o;
  logic [7:0] port_dir_o, s_axi_awaddr, s_axi_araddr;
  logic in_reset_o, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, scratch;
  int err_count = 0, comparisons = 0, cycles = 0, seed = 40;
  // ==========
  // Instances
  // Short timer counts keep the run small
  qclk_top #(.POWER_UP_TIMER_COUNT(20), .OST_COUNT(8)) qclk_top_i (.*);
  prog_mem_model prog_mem_model_i (.addr_i(prog_addr_o), .word_i(word), .data_o(prog_data_i));
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  // ==========
  // Tasks
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      wrap_up();
    end
  end
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_awaddr <= ad; s_axi_wdata <= d; s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    rs = s_axi_bresp; s_axi_bready <= 0;
    if (n >= 50) err_count++;
  endtask
  task automatic axi_rd(input logic [7:0] ad);
    int n;
    n = 0;
    @(posedge clk_i);
    s_axi_araddr <= ad; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(posedge clk_i);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rd = s_axi_rdata; rs = s_axi_rresp; s_axi_rready <= 0;
    if (n >= 50) err_count++;
  endtask
  task automatic wait_core(input logic v);
    int n;
    n = 0;
    while (in_reset_o !== v && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) err_count++;
  endtask
  // Cause flags {TO, PD, BOR, POR} after watchdog, master clear, brown-out
  function automatic logic [3:0] cause_flags(input int k);
    return (k == 0) ? 4'h7 : (k == 1) ? 4'hF : 4'hD;
  endfunction
  task automatic pulse(input int k);
    @(posedge clk_i);
    if (k == 0) watchdog_timeout_i <= 1;
    else if (k == 1) master_clear_n_i <= 0;
    else brown_out_i <= 1;
    repeat (4) @(posedge clk_i);
    watchdog_timeout_i <= 0; master_clear_n_i <= 1; brown_out_i <= 0;
    wait_core(1);
    wait_core(0);
  endtask
  // ==========
  // Main sequence
  initial begin
    {nrst_i, supply_good_i, brown_out_i, watchdog_timeout_i, s_axi_awvalid} = 0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, osc_mode_select_i} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
    master_clear_n_i = 1; s_axi_wstrb = 4'hF; word = 16'h0000;
    for (int m = 0; m < 4; m++) begin
      nrst_i <= 0; supply_good_i <= 0; osc_mode_select_i <= 2'(m);
      repeat (6) @(posedge clk_i);
      nrst_i <= 1;
      repeat (3) @(posedge clk_i);
      supply_good_i <= 1;
      wait_core(0);
      repeat (2) @(posedge clk_i);
      `CHK(osc_out_en_o, m[1])
      axi_rd(STATUS_ADDR);
      `CHK(rd[9:8], 2'(m))
      `CHK(rd[4:0], 5'h0C)
      for (int n = 0; n < 8 && phase_o !== 4'h1; n++) @(posedge clk_i);
      a = prog_addr_o;
      repeat (4) @(posedge clk_i);
      `CHK(prog_addr_o, a + 16'h1)
    end
    word <= 16'($random(seed)) | 16'h1;
    repeat (12) @(posedge clk_i);
    axi_rd(IR_ADDR);
    `CHK(rd[15:0], word)
    tgt = 16'($random(seed)) & 16'h7FFF;
    axi_wr(CTRL_ADDR, {tgt, 16'h0001});
    for (int n = 0; n < 40 && prog_addr_o !== tgt; n++) @(posedge clk_i);
    `CHK(prog_addr_o, tgt)
    axi_wr(CTRL_ADDR, 32'h0);
    scratch = $random(seed);
    axi_wr(SCRATCH_ADDR, scratch);
    axi_wr(DDR_ADDR, 32'h0);
    @(posedge clk_i);
    `CHK(port_dir_o, 8'h00)
    for (int k = 0; k < 3; k++) begin
      axi_wr(STATUS_ADDR, 32'h3);
      pulse(k);
      axi_rd(STATUS_ADDR);
      `CHK(rd[3:0], cause_flags(k))
      `CHK(port_dir_o, 8'hFF)
      axi_rd(SCRATCH_ADDR);
      `CHK(rd, scratch)
    end
    axi_rd(8'h40);
    `CHK(rs, AXI_SLVERR)
    supply_good_i <= 0;
    wait_core(1);
    repeat (3) @(posedge clk_i);
    `CHK(phase_o, 4'h1)
    supply_good_i <= 1;
    wait_core(0);
    wrap_up();
  end
endmodule
